// [sim/tsmh_host_tb_top.sv]
// Testbench: spawn host driven over the register bus against the spawner
`timescale 1ns/1ps
`default_nettype none
module tsmh_host_tb_top
   import tsmh_pkg::*;
;
   typedef struct {
      logic [276:0] v;  // Expected descriptor, payload, end flag
      logic [276:0] m;  // Bits that are fixed
   } tsmh_exp_t;
   logic         clk_sys, reset_n, rd, wr, waitreq;   // Clock, reset, bus
   logic [5:0]   address;                             // Bus address
   logic [31:0]  wdata, rdata, rv;                    // Bus data, last read
   logic         valid, ready, end_of_thread_flag, hold, misuse;     // Link and model
   logic [19:0]  desc;                                // Descriptor seen
   logic [255:0] payload;                             // Payload seen
   logic [7:0]   roots;                               // Roots dispatched
   logic [31:0]  regv[6];                             // Field registers
   int           mismatches, n_checks, n_roots, k;    // Counters
   tsmh_exp_t    q[$], e_mon;                         // Pending messages

   tsmh_host DUT (.CLK_SYS(clk_sys), .RESET_N(reset_n),
      .AVS_ADDRESS(address), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(waitreq), .MSG_VALID(valid), .MSG_READY(ready),
      .MSG_DESC(desc), .MSG_PAYLOAD(payload), .MSG_END_OF_THREAD(end_of_thread_flag));
   tsmh_spawner_model partner (.clk(clk_sys), .rst_n(reset_n),
      .hold(hold), .valid(valid), .desc(desc), .payload(payload),
      .end_of_thread_flag(end_of_thread_flag), .ready(ready), .misuse(misuse), .roots(roots));

   // 25 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [276:0] got, input logic [276:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   task automatic end_sim;
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim

   // One bus cycle; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clk_sys);
      address <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      do begin
         @(posedge clk_sys);
         i++;
      end while (waitreq !== 1'b0 && i < 40);
      if (i >= 40) begin
         check(277'h1, 277'h0);
         end_sim();
      end
      rv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   // Issue a command; note the message it must produce, then check err if wt is set
   task automatic send(input logic [2:0] c, input logic ch, input logic s,
                       input logic ok, input logic wt);
      tsmh_exp_t    e;
      logic [255:0] p, pm;
      logic         op, sel;
      int           i;
      op = (c < 3'h2);
      sel = (c == 3'h1) || (c == 3'h2) || (c == 3'h4);
      p = '0;
      pm = '0;
      p[15:0] = regv[0][15:0];
      pm[15:0] = '1;
      if (op) begin
         p[DW_ENTRY*32 +: 16] = regv[1][15:0];
         pm[DW_ENTRY*32 +: 16] = '1;
         p[DW_IDP*32+4 +: 28] = regv[2][31:4];
         pm[DW_IDP*32+4 +: 28] = {28{c == 3'h0}};
      end else begin
         p[DW_FFTID*32 +: 8] = regv[3][7:0];
         pm[DW_FFTID*32 +: 8] = '1;
      end
      p[DW_TCOUNT*32 +: 32] = {8'h00, regv[4][23:0]};
      p[DW_PCOUNT*32 +: 32] = {s, 7'h00, regv[5][23:0]};
      pm[255:192] = '1;
      e.v = {15'h0, sel, 2'b00, ch, op, p, c == 3'h4};
      e.m = {20'hfffff, pm, 1'b1};
      if (ok)
         q.push_back(e);
      if (ok && c == 3'h1)
         n_roots++;
      bus(1'b1, REG_CTRL, {26'h0, s, ch, 1'b1, c});
      if (wt) begin
         hold <= 1'b0;
         i = 0;
         do begin
            bus(1'b0, REG_STATUS, 32'h0);
            i++;
         end while (rv[0] !== 1'b0 && i < 60);
         check(277'(i >= 60), 277'h0);
         if (i >= 60)
            end_sim();
         check(277'(rv[2]), 277'(!ok));
         bus(1'b1, REG_STATUS, 32'h4);
      end
   endtask : send

   // Every accepted message is matched against the oldest note
   always @(posedge clk_sys) begin
      if (valid === 1'b1 && ready === 1'b1) begin
         if (q.size() == 0) begin
            check(277'h1, 277'h0);
         end else begin
            e_mon = q.pop_front();
            check({desc, payload, end_of_thread_flag} & e_mon.m, e_mon.v & e_mon.m);
         end
      end
   end

   initial begin
      reset_n = 1'b0;
      address = 6'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      hold = 1'b0;
      mismatches = 0;
      n_checks = 0;
      n_roots = 0;
      void'($urandom(91));
      for (k = 0; k < 6; k++)
         regv[k] = $urandom();
      regv[1] = (regv[1] & 32'hffff) | 32'h0400;  // Entry count above 0
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      // Idle status, unmapped read and write
      bus(1'b0, REG_STATUS, 32'h0);
      check(277'(rv), 277'h0);
      bus(1'b1, 6'h3c, 32'hffffffff);
      bus(1'b0, 6'h3c, 32'h0);
      check(277'(rv), 277'h0);
      for (k = 0; k < 6; k++)
         bus(1'b1, REG_HANDLE + 6'(4 * k), regv[k]);
      bus(1'b1, REG_ROOTS, 32'h2);
      send(3'h0, 1'b0, 1'b0, 1'b1, 1'b1);
      send(3'h1, 1'b0, 1'b1, 1'b1, 1'b1);
      send(3'h2, 1'b0, 1'b0, 1'b1, 1'b1);
      send(3'h3, 1'b0, 1'b1, 1'b1, 1'b1);
      send(3'h3, 1'b0, 1'b0, 1'b0, 1'b1);
      send(3'h2, 1'b1, 1'b0, 1'b1, 1'b1);
      send(3'h1, 1'b1, 1'b0, 1'b0, 1'b1);
      send(3'h1, 1'b0, 1'b0, 1'b1, 1'b1);
      send(3'h1, 1'b0, 1'b0, 1'b0, 1'b1);
      bus(1'b0, REG_SENT, 32'h0);
      check(277'(rv[7:0]), 277'h2);
      // A fresh handle may be released again
      regv[0] = regv[0] ^ 32'h1;
      bus(1'b1, REG_HANDLE, regv[0]);
      send(3'h3, 1'b0, 1'b0, 1'b1, 1'b1);
      // Zero entry count: root refused, child allowed
      regv[1] = regv[1] & 32'h03ff;
      bus(1'b1, REG_ENTRY, regv[1]);
      bus(1'b1, REG_ROOTS, 32'h1);
      send(3'h1, 1'b0, 1'b0, 1'b0, 1'b1);
      send(3'h0, 1'b0, 1'b0, 1'b1, 1'b1);
      // A go while a message stalls is refused
      hold <= 1'b1;
      send(3'h0, 1'b0, 1'b1, 1'b1, 1'b0);
      send(3'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      send(3'h4, 1'b0, 1'b0, 1'b1, 1'b1);
      send(3'h4, 1'b0, 1'b0, 1'b0, 1'b1);
      check(277'(misuse), 277'h0);
      check(277'(roots), 277'(n_roots));
      check(277'(q.size()), 277'h0);
      end_sim();
   end
endmodule : tsmh_host_tb_top
`default_nettype wire

// [sim/tsmh_spawner_model.sv]
// Partner model: the thread spawner at the far end of the message link
`timescale 1ns/1ps
`default_nettype none
module tsmh_spawner_model
   import tsmh_pkg::*;
(
   input  wire logic         clk,      // Core clock
   input  wire logic         rst_n,    // Async reset, low
   input  wire logic         hold,     // Bench forces a long stall
   input  wire logic         valid,    // Message offered
   input  wire logic [19:0]  desc,     // Descriptor
   input  wire logic [255:0] payload,  // Eight dwords in one beat
   input  wire logic         end_of_thread_flag,      // End of thread flag
   output logic              ready,    // Accept strobe
   output logic              misuse,   // Sticky: host broke a rule
   output logic [7:0]        roots     // Root threads dispatched
);
   logic        freed;    // A handle has been released
   logic [15:0] freed_h;  // The handle that was released
   logic        acc;      // Message taken at this edge
   assign acc = valid && ready;
   // Random stalls, so the host never counts on a quick spawner
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ready   <= 1'b0;
         misuse  <= 1'b0;
         roots   <= 8'h00;
         freed   <= 1'b0;
         freed_h <= 16'h0000;
      end else begin
         ready <= !hold && ($urandom_range(2) != 0);
         if (acc && (desc & DESC_MBZ_MASK) != 20'h00000)
            misuse <= 1'b1;
         // Child spawns fetch from handle and offset; no header is made
         if (acc && desc[DESC_OPCODE_BIT] == OP_SPAWN) begin
            if (end_of_thread_flag)
               misuse <= 1'b1;
            if (desc[DESC_RSEL_BIT]) begin
               roots <= roots + 8'h01;
               if (payload[DW_ENTRY*32+10 +: 6] == 6'h00)
                  misuse <= 1'b1;
            end
         end
         // Only a root requester frees anything; completion seen only here
         if (acc && desc[DESC_OPCODE_BIT] == OP_DEREF &&
             desc[DESC_REQ_BIT] == REQ_ROOT && !desc[DESC_RSEL_BIT]) begin
            if (freed && freed_h == payload[15:0])
               misuse <= 1'b1;
            freed   <= 1'b1;
            freed_h <= payload[15:0];
         end
      end
   end
endmodule : tsmh_spawner_model
`default_nettype wire

// [verilog/tsmh_host.sv]
// Spawn host: Avalon-controlled sender of thread spawn messages
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Message is exactly eight dwords
// - Never release same handle twice (freed clears on any handle write, even of the same value)
// - Reserved descriptor bits driven zero
// - Root thread ends with deref, end flag
// - Never end thread with spawn opcode
// - Child should also end with deref
// - One spawn-root per expected root thread
// - Ten-bit offset versus six-bit writes
// - Parent count in last dword bits 23:0
// - Unique, order-independent child counts
// - Debug byte of dword six reserved
// - Requester type always set correctly
// - Zero entry count only for child
module tsmh_host
   import tsmh_pkg::*;
#(
   parameter int ROOT_CNT_W = 8      // Width of the root thread counters
)(
   input  wire logic         CLK_SYS,            // 25 MHz clock
   input  wire logic         RESET_N,            // Async reset, low
   input  wire logic [5:0]   AVS_ADDRESS,        // Byte address
   input  wire logic         AVS_READ,           // Read strobe
   input  wire logic         AVS_WRITE,          // Write strobe
   input  wire logic [31:0]  AVS_WRITEDATA,      // Write data
   input  wire logic [3:0]   AVS_BYTEENABLE,     // Byte lanes
   output logic      [31:0]  AVS_READDATA,       // Read data
   output logic              AVS_WAITREQUEST,    // Stall
   output logic              MSG_VALID,          // Message offered
   input  wire logic         MSG_READY,          // Spawner accepts
   output logic      [19:0]  MSG_DESC,           // Descriptor
   output logic      [255:0] MSG_PAYLOAD,        // Eight dwords
   output logic              MSG_END_OF_THREAD   // End of thread flag
);
   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_ERR} tsmh_state_t;

   // Whole module state
   typedef struct packed {
      tsmh_state_t              st;        // Sequencer state
      logic [2:0]               cmd;       // Latched command
      logic                     child;     // Requester is child
      logic                     snap;      // Snapshot request
      logic [15:0]              handle;    // Dispatch handle
      logic [15:0]              entry;     // Count and offset
      logic [27:0]              idp;       // Descriptor pointer
      logic [7:0]               fftid;     // Resource id
      logic [23:0]              tcount;    // Thread count
      logic [23:0]              pcount;    // Parent count
      logic [ROOT_CNT_W-1:0]    roots;     // Expected root threads
      logic [ROOT_CNT_W-1:0]    sent;      // Spawn-root sent
      logic                     freed;     // Handle already released
      logic                     ended;     // End of thread sent
      logic                     err;       // Refused command
      logic                     ack;       // Bus answer pending
      logic [31:0]              rdata;     // Read data
      logic                     v;         // Message valid
      logic [19:0]              desc;      // Held descriptor
      logic [255:0]             pay;       // Held payload
      logic                     end_of_thread_flag;       // Held end flag
   } tsmh_reg_t;

   tsmh_reg_t s_q;      // Registered state
   tsmh_reg_t s_d;      // Next state
   logic [19:0]  b_desc;     // Built descriptor
   logic [255:0] b_pay;      // Built payload
   logic         bus_req;    // Bus request pending

   // Combinational packer sees the latched order
   tsmh_msg_build u_build (
      .cmd       (s_q.cmd),
      .is_child  (s_q.child),
      .handle    (s_q.handle),
      .entry_off (s_q.entry[OFFSET_W-1:0]),
      .entry_cnt (s_q.entry[OFFSET_W+COUNT_W-1:OFFSET_W]),
      .idp       (s_q.idp),
      .fftid     (s_q.fftid),
      .tcount    (s_q.tcount),
      .pcount    (s_q.pcount),
      .snap      (s_q.snap),
      .desc      (b_desc),
      .payload   (b_pay)
   );

   assign bus_req = AVS_READ || AVS_WRITE;

   // Next-state logic: bus slave plus message sequencer
   always_comb begin
      logic        go;
      logic [2:0]  c;
      logic        refuse;
      go     = 1'b0;
      c      = 3'h0;
      refuse = 1'b0;
      s_d    = s_q;
      s_d.ack = 1'b0;
      // One wait state: answer at the second edge
      if (bus_req && !s_q.ack) begin
         s_d.ack = 1'b1;
         s_d.rdata = '0;
         if (AVS_READ) begin
            unique case (AVS_ADDRESS)
               REG_CTRL:   s_d.rdata = {26'h0, s_q.snap, s_q.child,
                                        1'b0, s_q.cmd};
               REG_STATUS: s_d.rdata = {27'h0, s_q.ended, s_q.freed,
                                        s_q.err, s_q.v,
                                        s_q.st != ST_IDLE};
               REG_HANDLE: s_d.rdata = {16'h0, s_q.handle};
               REG_ENTRY:  s_d.rdata = {16'h0, s_q.entry};
               REG_IDP:    s_d.rdata = {s_q.idp, 4'h0};
               REG_FFTID:  s_d.rdata = {24'h0, s_q.fftid};
               REG_TCOUNT: s_d.rdata = {8'h0, s_q.tcount};
               REG_PCOUNT: s_d.rdata = {8'h0, s_q.pcount};
               REG_ROOTS:  s_d.rdata = 32'(s_q.roots);
               REG_SENT:   s_d.rdata = 32'(s_q.sent);
               default:    s_d.rdata = '0;
            endcase
         end else if (AVS_BYTEENABLE[0]) begin
            // Only full-word writes are meaningful; lane 0 gates them
            unique case (AVS_ADDRESS)
               REG_CTRL: begin
                  c = AVS_WRITEDATA[2:0];
                  go = AVS_WRITEDATA[CTRL_GO_BIT];
                  // A pending message keeps its order until accepted,
                  // so the accept bookkeeping still sees the sent command
                  if (s_q.st == ST_IDLE) begin
                     s_d.cmd = c;
                     s_d.child = AVS_WRITEDATA[CTRL_CHILD_BIT];
                     s_d.snap = AVS_WRITEDATA[CTRL_SNAP_BIT];
                  end
               end
               REG_STATUS: s_d.err = s_q.err & ~AVS_WRITEDATA[2];
               REG_HANDLE: begin
                  s_d.handle = AVS_WRITEDATA[15:0];
                  s_d.freed = 1'b0;            // New handle, may free again
               end
               REG_ENTRY:  s_d.entry = AVS_WRITEDATA[15:0];
               REG_IDP:    s_d.idp = AVS_WRITEDATA[31:4];
               REG_FFTID:  s_d.fftid = AVS_WRITEDATA[7:0];
               REG_TCOUNT: s_d.tcount = AVS_WRITEDATA[23:0];
               REG_PCOUNT: s_d.pcount = AVS_WRITEDATA[23:0];
               REG_ROOTS:  begin
                  s_d.roots = AVS_WRITEDATA[ROOT_CNT_W-1:0];
                  s_d.sent = '0;
               end
               default: ;
            endcase
         end
      end
      // Command issue: refuse orders the spawner must never see
      if (go) begin
         unique case (tsmh_cmd_t'(c))
            TSMH_CMD_SPAWN_ROOT:
               refuse = (s_q.sent == s_q.roots)
                     || (AVS_WRITEDATA[CTRL_CHILD_BIT] == REQ_CHILD)
                     || (s_q.entry[OFFSET_W+COUNT_W-1:OFFSET_W] == '0);
            TSMH_CMD_DEREF_FREE:  refuse = s_q.freed;
            TSMH_CMD_SPAWN_CHILD: refuse = 1'b0;
            TSMH_CMD_DEREF_KEEP:  refuse = 1'b0;
            TSMH_CMD_END_THREAD:  refuse = s_q.ended;
            default:              refuse = 1'b1;
         endcase
         if (s_q.st != ST_IDLE) begin
            // Busy: flag it, but the pending message must not be disturbed
            s_d.err = 1'b1;
         end else if (refuse) begin
            s_d.err = 1'b1;
            s_d.st = ST_ERR;
         end else begin
            s_d.st = ST_SEND;
         end
      end
      // Sequencer
      unique case (s_q.st)
         ST_IDLE: ;
         // Refused order: shows busy for one cycle, then back to idle
         ST_ERR:  if (!go) s_d.st = ST_IDLE;
         ST_SEND: begin
            if (!s_q.v) begin
               s_d.v = 1'b1;
               s_d.desc = b_desc;
               s_d.pay = b_pay;
               // End only ever travels with the dereference opcode
               s_d.end_of_thread_flag = (s_q.cmd == TSMH_CMD_END_THREAD);
            end else if (MSG_READY) begin
               s_d.v = 1'b0;
               s_d.end_of_thread_flag = 1'b0;
               s_d.st = ST_IDLE;
               if (s_q.cmd == TSMH_CMD_SPAWN_ROOT) begin
                  s_d.sent = s_q.sent + 1'b1;
               end
               if (s_q.cmd == TSMH_CMD_DEREF_FREE) begin
                  s_d.freed = 1'b1;
               end
               if (s_q.cmd == TSMH_CMD_END_THREAD) begin
                  s_d.ended = 1'b1;
               end
            end
         end
         default: s_d.st = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign AVS_WAITREQUEST   = bus_req && !s_q.ack;
   assign AVS_READDATA      = s_q.rdata;
   assign MSG_VALID         = s_q.v;
   assign MSG_DESC          = s_q.desc;
   assign MSG_PAYLOAD       = s_q.pay;
   assign MSG_END_OF_THREAD = s_q.end_of_thread_flag;

   // Checks
   AST_MBZ: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      MSG_VALID |-> (MSG_DESC & DESC_MBZ_MASK) == '0)
      else $error("reserved descriptor bits set");
   AST_EOT_OP: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      MSG_END_OF_THREAD |-> MSG_DESC[DESC_OPCODE_BIT] == OP_DEREF)
      else $error("end of thread with spawn opcode");
   AST_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      MSG_VALID && !MSG_READY |=> MSG_VALID && $stable(MSG_PAYLOAD)
      && $stable(MSG_DESC))
      else $error("message dropped before acceptance");
   AST_ROOT_LEN: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      MSG_VALID && MSG_DESC[DESC_OPCODE_BIT] && MSG_DESC[DESC_RSEL_BIT]
      |-> MSG_PAYLOAD[DW_ENTRY*DW_BITS+OFFSET_W +: COUNT_W] != '0)
      else $error("root spawn with zero length");
   AST_DBG: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      MSG_VALID
      |-> MSG_PAYLOAD[DW_TCOUNT*DW_BITS+DBG_LSB +: FFTID_W] == '0)
      else $error("debug byte used");
   AST_ROOTS: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      s_q.sent <= s_q.roots)
      else $error("too many root spawns");
   AST_FREE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      MSG_VALID && MSG_DESC[DESC_OPCODE_BIT] == OP_DEREF
      && !MSG_DESC[DESC_RSEL_BIT] |-> !s_q.freed)
      else $error("handle released twice");
   AST_WAIT: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      $rose(bus_req) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
      else $error("bus answer not after one wait");
   AST_SEND: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      s_q.st == ST_IDLE && s_d.st == ST_SEND |=> ##1 MSG_VALID)
      else $error("message not offered");
   // One beat per message: an accepted message never shows again
   AST_ONE_BEAT: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      MSG_VALID && MSG_READY |=> !MSG_VALID)
      else $error("message offered twice");
   // Root spawns only ever carry the root requester type
   AST_ROOT_REQ: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      MSG_VALID && MSG_DESC[DESC_OPCODE_BIT] && MSG_DESC[DESC_RSEL_BIT]
      |-> MSG_DESC[DESC_REQ_BIT] == REQ_ROOT)
      else $error("root spawn from a child requester");

   // Scenario covers
   // A go that lands while a message is still pending
   COV_BUSY_GO: cover property (@(posedge CLK_SYS)
      s_q.st == ST_SEND && s_d.err && !s_q.err);
   COV_ROOT: cover property (@(posedge CLK_SYS)
      MSG_VALID && MSG_READY && MSG_DESC[DESC_RSEL_BIT]
      && MSG_DESC[DESC_OPCODE_BIT]);
   COV_CHILD: cover property (@(posedge CLK_SYS)
      MSG_VALID && MSG_READY && !MSG_DESC[DESC_RSEL_BIT]
      && MSG_DESC[DESC_OPCODE_BIT]);
   COV_EOT: cover property (@(posedge CLK_SYS) MSG_VALID && MSG_READY
      && MSG_END_OF_THREAD);
   COV_ERR: cover property (@(posedge CLK_SYS) $rose(s_q.err));
endmodule : tsmh_host
`default_nettype wire

// [verilog/tsmh_msg_build.sv]
// Message builder: packs descriptor and eight payload dwords
`timescale 1ns/1ps
`default_nettype none
module tsmh_msg_build
   import tsmh_pkg::*;
(
   input  wire logic [2:0]          cmd,         // Host command code
   input  wire logic                is_child,    // Requester is a child
   input  wire logic [15:0]         handle,      // Dispatch handle
   input  wire logic [9:0]          entry_off,   // Entry offset
   input  wire logic [5:0]          entry_cnt,   // Entry count
   input  wire logic [27:0]         idp,         // Descriptor pointer
   input  wire logic [7:0]          fftid,       // Resource id
   input  wire logic [23:0]         tcount,      // Own thread count
   input  wire logic [23:0]         pcount,      // Parent thread count
   input  wire logic                snap,        // Snapshot request
   output logic      [19:0]         desc,        // Message descriptor
   output logic      [255:0]        payload      // Eight dwords
);
   logic [DW_BITS-1:0] dw [MSG_DWORDS];  // Dword view of payload
   logic               spawn;            // Opcode is spawn

   // Descriptor: reserved bits stay zero by construction
   always_comb begin
      spawn = (cmd == TSMH_CMD_SPAWN_CHILD) || (cmd == TSMH_CMD_SPAWN_ROOT);
      desc = '0;
      desc[DESC_OPCODE_BIT] = spawn ? OP_SPAWN : OP_DEREF;
      desc[DESC_REQ_BIT] = is_child ? REQ_CHILD : REQ_ROOT;
      // Spawn: root=1; deref: keep handle=1
      desc[DESC_RSEL_BIT] = (cmd == TSMH_CMD_SPAWN_ROOT)
                         || (cmd == TSMH_CMD_DEREF_KEEP)
                         || (cmd == TSMH_CMD_END_THREAD);
   end

   // Payload dwords; unused dwords stay zero
   always_comb begin
      for (int i = 0; i < MSG_DWORDS; i++) begin
         dw[i] = '0;
      end
      dw[DW_HANDLE][HANDLE_W-1:0] = handle;
      dw[DW_ENTRY] = {16'h0000, entry_cnt, entry_off};
      dw[DW_IDP] = {idp, 4'h0};
      dw[DW_FFTID][FFTID_W-1:0] = fftid;
      // Debug byte left zero for the system debug routine
      dw[DW_TCOUNT] = {8'h00, tcount};
      dw[DW_PCOUNT] = {snap, 7'h00, pcount};
   end

   // Flatten, dword 0 in the low bits
   genvar g;
   generate
      for (g = 0; g < MSG_DWORDS; g++) begin : g_flat
         assign payload[g*DW_BITS +: DW_BITS] = dw[g];
      end
   endgenerate
endmodule : tsmh_msg_build
`default_nettype wire

// [verilog/tsmh_pkg.sv]
// Package: descriptor, payload layout and command codes of the spawn host
package tsmh_pkg;
   // Message size
   localparam int MSG_DWORDS      = 8;
   localparam int DW_BITS         = 32;
   // Descriptor field positions
   localparam int DESC_OPCODE_BIT = 0;
   localparam int DESC_REQ_BIT    = 1;
   localparam int DESC_RSEL_BIT   = 4;
   localparam int DESC_WIDTH      = 20;
   localparam logic [19:0] DESC_MBZ_MASK = 20'h7ffec;
   // Opcode values
   localparam logic OP_DEREF = 1'b0;
   localparam logic OP_SPAWN = 1'b1;
   // Requester type
   localparam logic REQ_ROOT  = 1'b0;
   localparam logic REQ_CHILD = 1'b1;
   // Payload dword indices
   localparam int DW_HANDLE = 0;
   localparam int DW_IDP    = 2;
   localparam int DW_ENTRY  = 4;
   localparam int DW_FFTID  = 5;
   localparam int DW_TCOUNT = 6;
   localparam int DW_PCOUNT = 7;
   // Field widths
   localparam int HANDLE_W  = 16;
   localparam int OFFSET_W  = 10;
   localparam int COUNT_W   = 6;
   localparam int IDP_LSB   = 4;
   localparam int FFTID_W   = 8;
   localparam int TCOUNT_W  = 24;
   localparam int DBG_LSB   = 24;
   localparam int SNAP_BIT  = 31;
   // Host command codes
   typedef enum logic [2:0] {
      TSMH_CMD_SPAWN_CHILD = 3'h0,
      TSMH_CMD_SPAWN_ROOT  = 3'h1,
      TSMH_CMD_DEREF_KEEP  = 3'h2,
      TSMH_CMD_DEREF_FREE  = 3'h3,
      TSMH_CMD_END_THREAD  = 3'h4
   } tsmh_cmd_t;
   // Avalon register map (word offsets as byte addresses)
   localparam logic [5:0] REG_CTRL    = 6'h00;
   localparam logic [5:0] REG_STATUS  = 6'h04;
   localparam logic [5:0] REG_HANDLE  = 6'h08;
   localparam logic [5:0] REG_ENTRY   = 6'h0c;
   localparam logic [5:0] REG_IDP     = 6'h10;
   localparam logic [5:0] REG_FFTID   = 6'h14;
   localparam logic [5:0] REG_TCOUNT  = 6'h18;
   localparam logic [5:0] REG_PCOUNT  = 6'h1c;
   localparam logic [5:0] REG_ROOTS   = 6'h20;
   localparam logic [5:0] REG_SENT    = 6'h24;
   // Control register fields
   localparam int CTRL_GO_BIT   = 3;
   localparam int CTRL_CHILD_BIT = 4;
   localparam int CTRL_SNAP_BIT = 5;
endpackage : tsmh_pkg
